// >>> logic/ctw_center_winder_torque_calc.sv
// constant tension center winder speed and torque calculator
`timescale 1ns/1ps
module ctw_center_winder_torque_calc
	import ctw_pkg::*;
#(
	parameter int W = CTW_PW
)
(
	input  wire logic                core_clk,
	input  wire logic                nrst,
	input  wire logic                sampleTick,
	input  wire logic signed [W-1:0] lineSpd,
	input  wire logic signed [W-1:0] lineSum,
	input  wire logic                extDiamMode,
	input  wire logic signed [W-1:0] diamRatioExt,
	input  wire logic signed [W-1:0] winderFb,
	input  wire logic signed [W-1:0] winder100,
	input  wire logic signed [W-1:0] coreSet,
	input  wire logic                memReset,
	input  wire logic signed [W-1:0] inertiaComp,
	input  wire logic signed [W-1:0] frictionComp,
	input  wire logic signed [W-1:0] staticTorque,
	input  wire logic signed [W-1:0] tensionSet,
	input  wire logic signed [W-1:0] tensionSum,
	input  wire logic signed [W-1:0] taperDiam,
	input  wire logic signed [W-1:0] taperPct,
	input  wire logic signed [W-1:0] torqueSum,
	output logic signed      [W-1:0] diameter,
	output logic signed      [W-1:0] scaledWinder,
	output logic signed      [W-1:0] winderSpeed,
	output logic signed      [W-1:0] tensionDemand,
	output logic signed      [W-1:0] diamTorque,
	output logic signed      [W-1:0] frictionTorque,
	output logic signed      [W-1:0] inertiaTorque,
	output logic signed      [W-1:0] totalTorque,
	output logic                     resultValid
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic signed [CTW_DW-1:0] ext(input logic signed [W-1:0] x);
		return CTW_DW'(x);
	endfunction : ext

	function automatic logic signed [W-1:0] sat(input logic signed [CTW_DW-1:0] x);
		logic signed [CTW_DW-1:0] r;
		r = x;
		if (x > SAT_MAX)
			r = SAT_MAX;
		else if (x < SAT_MIN)
			r = SAT_MIN;
		return r[W-1:0];
	endfunction : sat

	// x * y / 100.00 %
	function automatic logic signed [CTW_DW-1:0] pctMul(
		input logic signed [CTW_DW-1:0] x,
		input logic signed [CTW_DW-1:0] y
	);
		logic signed [2*CTW_DW-1:0] p;
		p = (64'(x) * 64'(y)) / PCT_FULL_L;
		return p[CTW_DW-1:0];
	endfunction : pctMul

	function automatic logic signed [CTW_DW-1:0] limit(
		input logic signed [CTW_DW-1:0] x,
		input logic signed [CTW_DW-1:0] lo,
		input logic signed [CTW_DW-1:0] hi
	);
		logic signed [CTW_DW-1:0] r;
		r = x;
		if (x > hi)
			r = hi;
		else if (x < lo)
			r = lo;
		return r;
	endfunction : limit

	////////////////////////////////////////////////////////////////////////
	// sequencer: one pass through the shared divider per sample

	ctw_state_e state;
	ctw_state_e next_state;

	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:  if (sampleTick) next_state = ST_SCALE;
			ST_SCALE: next_state = ST_DIAM;
			ST_DIAM:  next_state = ST_SPEED;
			ST_SPEED: next_state = ST_TAPER;
			ST_TAPER: next_state = ST_SUM;
			ST_SUM:   next_state = ST_IDLE;
			default:  next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// one line speed sample per pass: every stage and the next acceleration
	// step work from the same value even while the line keeps moving
	logic signed [W-1:0]      lineSnap;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			lineSnap <= '0;
		else if (state == ST_IDLE && sampleTick)
			lineSnap <= lineSpd;
	end

	////////////////////////////////////////////////////////////////////////
	// shared divider
	// idle and sum stages park it on zero operands

	ctw_arith_if divOp ();
	ctw_muldiv uDiv (
		.op (divOp.unit)
	);

	logic signed [CTW_DW-1:0] diamInt;
	logic signed [CTW_DW-1:0] scaledInt;
	logic signed [CTW_DW-1:0] coreInt;

	assign diamInt   = ext(diameter);
	assign scaledInt = ext(scaledWinder);
	assign coreInt   = ext(coreSet);

	always_comb
	begin
		divOp.a = ZERO;
		divOp.b = ZERO;
		divOp.c = ZERO;
		case (state)
			ST_SCALE:
			begin
				divOp.a = ext(winderFb);
				divOp.b = PCT_FULL;
				divOp.c = ext(winder100);
			end
			ST_DIAM:
			begin
				divOp.a = ext(lineSnap);
				divOp.b = coreInt;
				divOp.c = scaledInt;
			end
			ST_SPEED:
			begin
				divOp.a = ext(lineSnap) + ext(lineSum);
				divOp.b = coreInt;
				divOp.c = diamInt;
			end
			ST_TAPER:
			begin
				divOp.a = diamInt - ext(taperDiam);
				divOp.b = PCT_FULL;
				divOp.c = PCT_FULL - ext(taperDiam);
			end
			default:
			begin
				divOp.a = ZERO;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// diameter

	logic signed [CTW_DW-1:0] memDiam;
	logic signed [CTW_DW-1:0] extDiam;
	logic                     lineMoving;

	// empty core reads 0 %, full roll 100 %
	assign extDiam    = coreInt + pctMul(ext(diamRatioExt), PCT_FULL - coreInt);
	assign lineMoving = (ext(lineSnap) > ZERO) && (scaledInt > ZERO);

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			scaledWinder <= '0;
		else if (state == ST_SCALE && !extDiamMode)
			scaledWinder <= sat(divOp.y);
	end

	// memory keeps tension torque alive through a stop
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			memDiam <= ZERO;
		else if (memReset)
			memDiam <= ZERO;
		else if (state == ST_DIAM && !extDiamMode && lineMoving)
			memDiam <= limit(divOp.y, coreInt, PCT_FULL);
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			diameter <= '0;
		else if (state == ST_DIAM)
		begin
			if (extDiamMode)
				diameter <= sat(limit(extDiam, ZERO, PCT_FULL));
			else if (lineMoving)
				diameter <= sat(limit(divOp.y, coreInt, PCT_FULL));
			else
				diameter <= sat(limit(memDiam, coreInt, PCT_FULL));
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			winderSpeed <= '0;
		else if (state == ST_SPEED)
			winderSpeed <= sat(divOp.y);
	end

	////////////////////////////////////////////////////////////////////////
	// friction and inertia

	logic signed [W-1:0]      prevLine;
	logic signed [CTW_DW-1:0] accel;
	logic signed [CTW_DW-1:0] taperFrac;
	logic signed [2*CTW_DW-1:0] inertProd;

	// falling or steady line gives no acceleration
	assign accel     = (lineSnap > prevLine) ? ext(lineSnap) - ext(prevLine) : ZERO;
	assign inertProd = (64'(accel) * 64'(ext(inertiaComp))) / INERT_DIV;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			prevLine <= '0;
		else if (state == ST_SUM)
			prevLine <= lineSnap;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			frictionTorque <= '0;
		else if (state == ST_TAPER)
			frictionTorque <= sat(pctMul(ext(lineSnap), ext(frictionComp)));
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			inertiaTorque <= '0;
		else if (state == ST_TAPER)
			inertiaTorque <= sat(inertProd[CTW_DW-1:0]);
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			taperFrac <= ZERO;
		else if (state == ST_TAPER)
			taperFrac <= limit(divOp.y, ZERO, PCT_FULL);
	end

	////////////////////////////////////////////////////////////////////////
	// tension and torque summation

	logic signed [CTW_DW-1:0] tensBase;
	logic signed [CTW_DW-1:0] taperCut;
	logic signed [CTW_DW-1:0] next_demand;
	logic signed [CTW_DW-1:0] next_diamTorque;

	assign tensBase = limit(ext(tensionSet) + ext(tensionSum), ZERO, PCT_FULL);
	assign taperCut = pctMul(pctMul(tensBase, ext(taperPct)), taperFrac);

	// below the taper diameter the full base tension passes through
	always_comb
	begin
		if (taperPct == '0 || diameter <= taperDiam)
			next_demand = tensBase;
		else
			next_demand = tensBase - taperCut;
		next_diamTorque = pctMul(next_demand, diamInt);
	end

	ctw_arith_if partOp ();
	ctw_arith_if totOp ();

	ctw_clamp uPart (
		.op (partOp.unit)
	);
	ctw_clamp uTot (
		.op (totOp.unit)
	);

	// partial sum clamps first, so inertia alone may reach past 100 %
	assign partOp.a = ext(frictionTorque) + ext(staticTorque)
	                + next_diamTorque + ext(torqueSum);
	assign partOp.b = -TORQ_LIM1;
	assign partOp.c = TORQ_LIM1;
	assign totOp.a  = partOp.y + ext(inertiaTorque);
	assign totOp.b  = -TORQ_LIM2;
	assign totOp.c  = TORQ_LIM2;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			tensionDemand <= '0;
		else if (state == ST_SUM)
			tensionDemand <= sat(next_demand);
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			diamTorque <= '0;
		else if (state == ST_SUM)
			diamTorque <= sat(next_diamTorque);
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			totalTorque <= '0;
		else if (state == ST_SUM)
			totalTorque <= sat(totOp.y);
	end

	// one-cycle pulse when every output but scaledWinder holds the new sample; scaledWinder updates only outside external mode
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			resultValid <= 1'b0;
		else
			resultValid <= (state == ST_SUM);
	end

endmodule : ctw_center_winder_torque_calc

// >>> logic/ctw_pkg.sv
// constants and types shared by the center winder torque calculator
// Function
// - winder speed = (line + sum) * core / diameter
// - external diameter from ratio and core setting
// - inertia torque only while line accelerates
// - friction torque proportional to line speed
// - static friction torque added into total sum
// - selector picks line/winder or external diameter
// - winder feedback scaled by settable 100% level
// - external ratio ignored outside external mode
// - hold speed-based diameter while line stopped
// - memory reset input clears stored diameter
// - tension demand from setpoint, sum, taper settings
// - taper reduction starts at taper diameter
// - zero taper percentage gives untapered tension
// - diameter torque = tension demand times diameter
// - friction, static, diameter, aux torque clamped 100%
// - add inertia, clamp total to 150%
package ctw_pkg;
	localparam int CTW_DW = 32;
	localparam int CTW_PW = 16;
	// 0.01 % units: 100.00 % is 10000
	localparam logic signed [31:0] PCT_FULL   = 32'sh0000_2710;
	localparam logic signed [63:0] PCT_FULL_L = 64'sh0000_0000_0000_2710;
	localparam logic signed [31:0] TORQ_LIM1  = 32'sh0000_2710;
	localparam logic signed [31:0] TORQ_LIM2  = 32'sh0000_3a98;
	localparam logic signed [63:0] INERT_DIV  = 64'sh0000_0000_0000_0064;
	localparam logic signed [31:0] SAT_MAX    = 32'sh0000_7fff;
	localparam logic signed [31:0] SAT_MIN    = 32'shffff_8000;
	localparam logic signed [31:0] ZERO       = 32'sh0000_0000;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_SCALE = 3'h1,
		ST_DIAM  = 3'h3,
		ST_SPEED = 3'h2,
		ST_TAPER = 3'h6,
		ST_SUM   = 3'h7
	} ctw_state_e;
endpackage : ctw_pkg

// >>> logic/ctw_arith_if.sv
// operand carrier between the calculator and its arithmetic units
`timescale 1ns/1ps
interface ctw_arith_if;
	import ctw_pkg::*;
	logic signed [CTW_DW-1:0] a;
	logic signed [CTW_DW-1:0] b;
	logic signed [CTW_DW-1:0] c;
	logic signed [CTW_DW-1:0] y;
	modport user (output a, output b, output c, input y);
	modport unit (input a, input b, input c, output y);
endinterface : ctw_arith_if

// >>> logic/ctw_muldiv.sv
// saturating y = a * b / c
`timescale 1ns/1ps
module ctw_muldiv
	import ctw_pkg::*;
(
	ctw_arith_if.unit op
);
	logic signed [2*CTW_DW-1:0] prod;
	logic signed [2*CTW_DW-1:0] quo;

	always_comb
	begin
		prod = 64'(op.a) * 64'(op.b);
		quo  = '0;
		if (op.c == ZERO)
		begin
			// no divisor: go to full scale in the sign of the numerator
			op.y = (prod < 0) ? SAT_MIN : SAT_MAX;
		end
		else
		begin
			quo = prod / 64'(op.c);
			if (quo > 64'(SAT_MAX))
				op.y = SAT_MAX;
			else if (quo < 64'(SAT_MIN))
				op.y = SAT_MIN;
			else
				op.y = quo[CTW_DW-1:0];
		end
	end
endmodule : ctw_muldiv

// >>> logic/ctw_clamp.sv
// y = a limited to the range b .. c
`timescale 1ns/1ps
module ctw_clamp
	import ctw_pkg::*;
(
	ctw_arith_if.unit op
);
	always_comb
	begin
		if (op.a > op.c)
			op.y = op.c;
		else if (op.a < op.b)
			op.y = op.b;
		else
			op.y = op.a;
	end
endmodule : ctw_clamp

// >>> dv/ctw_calc_sva.sv
// port-level checks for the winder calculator
`timescale 1ns/1ps
module ctw_calc_sva
	import ctw_pkg::*;
#(
	parameter int W = CTW_PW
)
(
	input wire logic	core_clk,
	input wire logic	nrst,
	input wire logic	sampleTick,
	input wire logic	resultValid,
	input wire logic	extDiamMode,
	input wire logic signed [W-1:0]	lineSpd,
	input wire logic signed [W-1:0]	lineSum,
	input wire logic signed [W-1:0]	diamRatioExt,
	input wire logic signed [W-1:0]	winderFb,
	input wire logic signed [W-1:0]	winder100,
	input wire logic signed [W-1:0]	coreSet,
	input wire logic signed [W-1:0]	frictionComp,
	input wire logic signed [W-1:0]	staticTorque,
	input wire logic signed [W-1:0]	torqueSum,
	input wire logic signed [W-1:0]	diameter,
	input wire logic signed [W-1:0]	scaledWinder,
	input wire logic signed [W-1:0]	winderSpeed,
	input wire logic signed [W-1:0]	tensionDemand,
	input wire logic signed [W-1:0]	diamTorque,
	input wire logic signed [W-1:0]	frictionTorque,
	input wire logic signed [W-1:0]	inertiaTorque,
	input wire logic signed [W-1:0]	totalTorque
);
	logic signed [31:0]	pSum, pClip, tSum, tClip, fExp, dExp, sExp, wExp;
	// divisions by zero only matter under guarded antecedents
	assign pSum = 32'(frictionTorque) + 32'(staticTorque) + 32'(diamTorque) + 32'(torqueSum);
	assign pClip = pSum > TORQ_LIM1 ? TORQ_LIM1 : (pSum < -TORQ_LIM1 ? -TORQ_LIM1 : pSum);
	assign tSum = pClip + 32'(inertiaTorque);
	assign tClip = tSum > TORQ_LIM2 ? TORQ_LIM2 : (tSum < -TORQ_LIM2 ? -TORQ_LIM2 : tSum);
	assign fExp = 32'(lineSpd) * 32'(frictionComp) / PCT_FULL;
	assign dExp = 32'(tensionDemand) * 32'(diameter) / PCT_FULL;
	assign sExp = (32'(lineSpd) + 32'(lineSum)) * 32'(coreSet) / 32'(diameter);
	assign wExp = 32'(winderFb) * PCT_FULL / 32'(winder100);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	chk_valid_pulse: assert property (resultValid |=> !resultValid) else $error("valid too long");
	chk_valid_delay: assert property (resultValid |-> $past(sampleTick, 6) || $past(sampleTick, 7))
		else $error("valid without tick");
	chk_diam_range: assert property (resultValid |-> diameter >= 0 && diameter <= PCT_FULL)
		else $error("diameter range");
	chk_ext_core: assert property (resultValid && extDiamMode && diamRatioExt == 0 |-> diameter == coreSet)
		else $error("empty core diameter");
	chk_winder_scale: assert property (resultValid && !extDiamMode && winder100 > 0 |-> scaledWinder == wExp[W-1:0])
		else $error("scaled winder");
	chk_speed_calc: assert property (resultValid && diameter > 0 |-> winderSpeed == sExp[W-1:0])
		else $error("winder speed");
	chk_friction_calc: assert property (resultValid |-> frictionTorque == fExp[W-1:0])
		else $error("friction torque");
	chk_diam_torque: assert property (resultValid |-> diamTorque == dExp[W-1:0])
		else $error("diameter torque");
	chk_total_sum: assert property (resultValid |-> totalTorque == tClip[W-1:0])
		else $error("total torque");
	chk_inertia_stop: assert property (resultValid && lineSpd == 0 |-> inertiaTorque == 0)
		else $error("inertia at stop");
	cover property (resultValid && extDiamMode);
	cover property (resultValid && !extDiamMode);
	cover property (resultValid && totalTorque == TORQ_LIM2);
endmodule : ctw_calc_sva

bind ctw_center_winder_torque_calc ctw_calc_sva #(.W(W)) u_sva (
	.core_clk(core_clk), .nrst(nrst), .sampleTick(sampleTick), .resultValid(resultValid),
	.extDiamMode(extDiamMode), .lineSpd(lineSpd), .lineSum(lineSum), .diamRatioExt(diamRatioExt),
	.winderFb(winderFb), .winder100(winder100), .coreSet(coreSet), .frictionComp(frictionComp),
	.staticTorque(staticTorque), .torqueSum(torqueSum), .diameter(diameter), .scaledWinder(scaledWinder),
	.winderSpeed(winderSpeed), .tensionDemand(tensionDemand), .diamTorque(diamTorque),
	.frictionTorque(frictionTorque), .inertiaTorque(inertiaTorque), .totalTorque(totalTorque));

// >>> dv/ctw_torque_reg_model.sv
// torque regulator stand-in that takes the total torque as reference
`timescale 1ns/1ps
module ctw_torque_reg_model
	import ctw_pkg::*;
(
	input wire logic	core_clk,
	input wire logic	nrst,
	input wire logic	refValid,
	input wire logic signed [CTW_PW-1:0]	torqueIn,
	output logic signed [CTW_PW-1:0]	torqueRef
);
	// torque mode only: the reference moves on the valid pulse alone
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			torqueRef <= '0;
		else if (refValid)
			torqueRef <= torqueIn;
	end
endmodule : ctw_torque_reg_model

// >>> dv/ctw_center_winder_torque_calc_bench.sv
// self-checking bench for the winder calculator
`timescale 1ns/1ps
module ctw_center_winder_torque_calc_bench
	import ctw_pkg::*;
;
	logic core_clk = 1'b0, nrst = 1'b0, sampleTick = 1'b0, extDiamMode = 1'b1, memReset = 1'b0, resultValid;
	logic signed [15:0] lineSpd = '0, lineSum = '0, diamRatioExt = '0, winderFb = '0, winder100 = 16'sh2710;
	logic signed [15:0] coreSet = 16'sh07d0, inertiaComp = '0, frictionComp = '0, staticTorque = '0;
	logic signed [15:0] tensionSet = '0, tensionSum = '0, taperDiam = '0, taperPct = '0, torqueSum = '0;
	logic signed [15:0] diameter, scaledWinder, winderSpeed, tensionDemand, diamTorque;
	logic signed [15:0] frictionTorque, inertiaTorque, totalTorque, torqueRef;
	logic signed [15:0] rat[3] = '{16'sh0000, 16'sh1388, 16'sh2710};
	logic signed [15:0] dia[3] = '{16'sh07d0, 16'sh1770, 16'sh2710};
	int fails = 0, tests_run = 0, cyc = 0;

	ctw_center_winder_torque_calc #(.W(16)) u_dut (
		.core_clk(core_clk), .nrst(nrst), .sampleTick(sampleTick), .lineSpd(lineSpd), .lineSum(lineSum),
		.extDiamMode(extDiamMode), .diamRatioExt(diamRatioExt), .winderFb(winderFb), .winder100(winder100),
		.coreSet(coreSet), .memReset(memReset), .inertiaComp(inertiaComp), .frictionComp(frictionComp),
		.staticTorque(staticTorque), .tensionSet(tensionSet), .tensionSum(tensionSum), .taperDiam(taperDiam),
		.taperPct(taperPct), .torqueSum(torqueSum), .diameter(diameter), .scaledWinder(scaledWinder),
		.winderSpeed(winderSpeed), .tensionDemand(tensionDemand), .diamTorque(diamTorque),
		.frictionTorque(frictionTorque), .inertiaTorque(inertiaTorque), .totalTorque(totalTorque),
		.resultValid(resultValid));
	ctw_torque_reg_model u_reg (.core_clk(core_clk), .nrst(nrst), .refValid(resultValid),
		.torqueIn(totalTorque), .torqueRef(torqueRef));

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic signed [15:0] got, input logic signed [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %0d want %0d", $time, got, exp);
		end
	endtask : chk

	// one pass: tick for a cycle, then wait a bounded time for the result
	task automatic run();
		@(posedge core_clk) #1 sampleTick = 1'b1;
		@(posedge core_clk) #1 sampleTick = 1'b0;
		for (int i = 0; i < 12 && resultValid !== 1'b1; i++)
			@(posedge core_clk) #1;
		chk({15'h0000, resultValid}, 16'sh0001);
		// inputs hold through the valid cycle, where the checker samples them
		@(posedge core_clk) #1;
	endtask : run

	task automatic tally_and_finish();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		repeat (5) @(posedge core_clk);
		#1 nrst = 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			diamRatioExt = rat[k];
			run();
			chk(diameter, dia[k]);
		end
		extDiamMode = 1'b0;
		lineSpd = 16'sh1388;
		lineSum = 16'sh03e8;
		winderFb = 16'sh09c4;
		diamRatioExt = 16'sh2328;
		run();
		chk(scaledWinder, 16'sh09c4);
		chk(diameter, 16'sh0fa0);
		chk(winderSpeed, 16'sh0bb8);
		lineSpd = '0;
		run();
		chk(diameter, 16'sh0fa0);
		memReset = 1'b1;
		run();
		chk(diameter, 16'sh07d0);
		memReset = 1'b0;
		winder100 = '0;
		run();
		chk(scaledWinder, 16'sh7fff);
		winder100 = 16'sh2710;
		extDiamMode = 1'b1;
		diamRatioExt = 16'sh1388;
		tensionSet = 16'sh1770;
		tensionSum = 16'sh03e8;
		taperDiam = 16'sh07d0;
		run();
		chk(tensionDemand, 16'sh1b58);
		chk(diamTorque, 16'sh1068);
		taperPct = 16'sh1388;
		run();
		chk(tensionDemand, 16'sh1482);
		chk(diamTorque, 16'sh0c4e);
		taperDiam = 16'sh1770;
		run();
		chk(tensionDemand, 16'sh1b58);
		lineSpd = 16'sh1388;
		frictionComp = 16'sh03e8;
		run();
		chk(frictionTorque, 16'sh01f4);
		chk(totalTorque, 16'sh125c);
		@(posedge core_clk) #1;
		chk(torqueRef, 16'sh125c);
		inertiaComp = 16'sh00c8;
		lineSpd = 16'sh1770;
		run();
		chk(inertiaTorque, 16'sh07d0);
		chk(totalTorque, 16'sh1a90);
		run();
		chk(inertiaTorque, 16'sh0000);
		lineSpd = 16'sh0fa0;
		run();
		chk(inertiaTorque, 16'sh0000);
		staticTorque = 16'sh2328;
		torqueSum = 16'sh1388;
		inertiaComp = 16'sh0064;
		lineSpd = 16'sh2710;
		run();
		chk(totalTorque, 16'sh3a98);
		inertiaComp = '0;
		torqueSum = 16'sh8ad0;
		run();
		chk(totalTorque, 16'shd8f0);
		torqueSum = '0;
		staticTorque = 16'sh03e8;
		run();
		chk(totalTorque, 16'sh1838);
		tally_and_finish();
	end
endmodule : ctw_center_winder_torque_calc_bench
